/* File: hdl/trig_route_pkg.sv */
// Purpose: shared constants and types for the cross-trigger router
// Assumes: APB slave, 32-bit data, one 20 MHz clock
// Notes: select codes are two bits, code 1 names line a and code 2 line b, 0 and 3 name neither
package trig_route_pkg;

    localparam int CLK_PERIOD_NS = 50;
    // monitor hold while break enables are changed
    localparam int MONITOR_HOLD_NS = 200;
    localparam int MONITOR_HOLD_CYC = (MONITOR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] OFS_ANALYZER_SEL = 8'h00;
    localparam logic [7:0] OFS_COAX_CTL = 8'h04;
    localparam logic [7:0] OFS_BUS_CTL = 8'h08;
    localparam logic [7:0] OFS_BREAK_EN = 8'h0c;
    localparam logic [7:0] OFS_BREAK_UNKNOWN = 8'h10;
    localparam logic [7:0] OFS_BREAK_CMD = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // analyzer output select codes
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_A = 2'h1;
    localparam logic [1:0] SEL_B = 2'h2;

    // field positions of the routing control words
    localparam int EMU_SEL_LSB = 0;
    localparam int STATE_SEL_LSB = 2;
    localparam int DRV_LSB = 0;
    localparam int RCV_LSB = 2;

    // break enable bit positions
    localparam int BRK_SOFT_BP = 0;
    localparam int BRK_ROM = 1;
    localparam int BRK_COAX = 2;
    localparam int BRK_BUS = 3;
    localparam int BRK_LINE_A = 4;
    localparam int BRK_LINE_B = 5;
    localparam int BRK_W = 6;

    // soft breakpoints enabled, all else off
    localparam logic [5:0] BREAK_EN_RESET = 6'h01;

    typedef struct packed {
        logic [1:0] state_sel;
        logic [1:0] emu_sel;
    } analyzer_sel_t;

    typedef struct packed {
        logic [1:0] rcv;
        logic [1:0] drv;
    } port_route_t;

    typedef struct packed {
        logic line_b;
        logic line_a;
    } trig_lines_t;

    typedef enum logic [1:0] {
        UPD_IDLE,
        UPD_HOLD,
        UPD_RESUME
    } upd_state_t;

endpackage : trig_route_pkg

/* File: hdl/cross_trigger_router.sv */
// Purpose: cross-trigger routing between analyzers, coax and bus trigger, and break requests
// Assumes: pins synchronous to clk except coax and bus trigger inputs; apb zero extra wait
// Notes: break_req stays high until monitor_ack
`timescale 1ns/1ps

module cross_trigger_router (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic emu_trig_found,
    input wire logic state_trig_found,
    input wire logic coax_trig_in,
    output logic coax_trig_out,
    input wire logic bus_trig_in,
    output logic bus_trig_out,
    output trig_route_pkg::trig_lines_t trig_lines,
    input wire logic soft_bp_hit,
    input wire logic mem_write,
    input wire logic rom_mapped,
    input wire logic target_hw_reset,
    input wire logic proc_in_reset,
    input wire logic monitor_ack,
    output logic break_req,
    output logic reset_release,
    output logic monitor_hold
);

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        logic [2:0] idx;
        idx = 3'h7;
        if (addr == trig_route_pkg::OFS_ANALYZER_SEL) begin
            idx = 3'h0;
        end else if (addr == trig_route_pkg::OFS_COAX_CTL) begin
            idx = 3'h1;
        end else if (addr == trig_route_pkg::OFS_BUS_CTL) begin
            idx = 3'h2;
        end else if (addr == trig_route_pkg::OFS_BREAK_EN) begin
            idx = 3'h3;
        end else if (addr == trig_route_pkg::OFS_BREAK_UNKNOWN) begin
            idx = 3'h4;
        end else if (addr == trig_route_pkg::OFS_BREAK_CMD) begin
            idx = 3'h5;
        end else if (addr == trig_route_pkg::OFS_STATUS) begin
            idx = 3'h6;
        end
        return idx;
    endfunction : reg_index

    // a two-bit select turned into a line mask
    function automatic logic [1:0] sel_mask(input logic [1:0] sel);
        logic [1:0] m;
        m = 2'h0;
        if (sel == trig_route_pkg::SEL_A) begin
            m = 2'h1;
        end else if (sel == trig_route_pkg::SEL_B) begin
            m = 2'h2;
        end
        return m;
    endfunction : sel_mask

    // AND of the chosen lines, false when none chosen
    function automatic logic rcv_and(input logic [1:0] rcv, input logic [1:0] lines);
        return (rcv != 2'h0) && ((lines & rcv) == rcv);
    endfunction : rcv_and

    logic [2:0] idx;
    logic wr_access;
    logic setup_rd;
    assign idx = reg_index(paddr);
    assign wr_access = ce && psel && penable && pwrite;
    assign setup_rd = ce && psel && !penable && !pwrite;
    assign pready = ce && psel && penable;
    assign pslverr = pready && (idx == 3'h7);

    ////////////////////////////////////////////////////////////////////////////////
    // trigger input synchronisers

    logic coax_meta;
    logic coax_sync;
    logic coax_prev;
    logic bus_meta;
    logic bus_sync;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coax_meta <= 1'b0;
            coax_sync <= 1'b0;
            coax_prev <= 1'b0;
            bus_meta <= 1'b0;
            bus_sync <= 1'b0;
        end else if (ce) begin
            coax_meta <= coax_trig_in;
            coax_sync <= coax_meta;
            coax_prev <= coax_sync;
            bus_meta <= bus_trig_in;
            bus_sync <= bus_meta;
        end
    end

    logic coax_rise;
    assign coax_rise = coax_sync && !coax_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // routing configuration registers

    trig_route_pkg::analyzer_sel_t ana_sel;
    trig_route_pkg::analyzer_sel_t next_ana_sel;
    trig_route_pkg::port_route_t coax_ctl;
    trig_route_pkg::port_route_t next_coax_ctl;
    trig_route_pkg::port_route_t bus_ctl;
    trig_route_pkg::port_route_t next_bus_ctl;

    always_comb begin
        next_ana_sel = ana_sel;
        next_coax_ctl = coax_ctl;
        next_bus_ctl = bus_ctl;
        if (wr_access && idx == 3'h0) begin
            next_ana_sel.emu_sel = pwdata[trig_route_pkg::EMU_SEL_LSB +: 2];
            next_ana_sel.state_sel = pwdata[trig_route_pkg::STATE_SEL_LSB +: 2];
        end
        if (wr_access && idx == 3'h1) begin
            next_coax_ctl.drv = pwdata[trig_route_pkg::DRV_LSB +: 2];
            next_coax_ctl.rcv = pwdata[trig_route_pkg::RCV_LSB +: 2];
        end
        if (wr_access && idx == 3'h2) begin
            next_bus_ctl.drv = pwdata[trig_route_pkg::DRV_LSB +: 2];
            next_bus_ctl.rcv = pwdata[trig_route_pkg::RCV_LSB +: 2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ana_sel <= '0;
            coax_ctl <= '0;
            bus_ctl <= '0;
        end else if (ce) begin
            ana_sel <= next_ana_sel;
            coax_ctl <= next_coax_ctl;
            bus_ctl <= next_bus_ctl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // internal trigger lines and outward routing

    logic [1:0] next_lines;
    logic next_coax_out;
    logic next_bus_out;

    always_comb begin
        next_lines = 2'h0;
        if (emu_trig_found) begin
            next_lines = next_lines | sel_mask(ana_sel.emu_sel);
        end
        if (state_trig_found) begin
            next_lines = next_lines | sel_mask(ana_sel.state_sel);
        end
        if (coax_sync) begin
            next_lines = next_lines | coax_ctl.drv;
        end
        if (bus_sync) begin
            next_lines = next_lines | bus_ctl.drv;
        end
        next_coax_out = rcv_and(coax_ctl.rcv, {trig_lines.line_b, trig_lines.line_a});
        next_bus_out = rcv_and(bus_ctl.rcv, {trig_lines.line_b, trig_lines.line_a});
    end

    // feedback via coax keeps line up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_lines <= '0;
            coax_trig_out <= 1'b0;
            bus_trig_out <= 1'b0;
        end else if (ce) begin
            trig_lines <= next_lines;
            coax_trig_out <= next_coax_out;
            bus_trig_out <= next_bus_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // break enable update with brief monitor hold

    logic [5:0] break_en;
    logic [5:0] next_break_en;
    logic [5:0] pend_en;
    logic [5:0] next_pend_en;
    logic [5:0] unknown;
    logic [5:0] next_unknown;
    logic [3:0] hold_cnt;
    logic [3:0] next_hold_cnt;
    trig_route_pkg::upd_state_t upd_state;
    trig_route_pkg::upd_state_t next_upd_state;

    always_comb begin
        next_break_en = break_en;
        next_pend_en = pend_en;
        next_unknown = unknown;
        next_hold_cnt = hold_cnt;
        next_upd_state = upd_state;
        case (upd_state)
            trig_route_pkg::UPD_IDLE: begin
                // one bit per cause, breakpoints shared
                // a write holds the monitor first
                if (wr_access && idx == 3'h3) begin
                    next_pend_en = pwdata[trig_route_pkg::BRK_W-1:0];
                    next_hold_cnt = 4'(trig_route_pkg::MONITOR_HOLD_CYC);
                    next_upd_state = trig_route_pkg::UPD_HOLD;
                end
            end
            trig_route_pkg::UPD_HOLD: begin
                // interrupted update leaves changed bits unknown
                if (target_hw_reset) begin
                    next_unknown = unknown | (pend_en ^ break_en);
                    next_pend_en = break_en;
                    next_upd_state = trig_route_pkg::UPD_IDLE;
                end else if (hold_cnt <= 4'h1) begin
                    next_unknown = unknown & ~(pend_en ^ break_en);
                    next_break_en = pend_en;
                    next_upd_state = trig_route_pkg::UPD_RESUME;
                end else begin
                    next_hold_cnt = hold_cnt - 4'h1;
                end
            end
            trig_route_pkg::UPD_RESUME: begin
                next_hold_cnt = 4'h0;
                next_upd_state = trig_route_pkg::UPD_IDLE;
            end
            default: begin
                next_upd_state = trig_route_pkg::UPD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            break_en <= trig_route_pkg::BREAK_EN_RESET;
            pend_en <= trig_route_pkg::BREAK_EN_RESET;
            unknown <= 6'h00;
            hold_cnt <= 4'h0;
            upd_state <= trig_route_pkg::UPD_IDLE;
        end else if (ce) begin
            break_en <= next_break_en;
            pend_en <= next_pend_en;
            unknown <= next_unknown;
            hold_cnt <= next_hold_cnt;
            upd_state <= next_upd_state;
        end
    end

    assign monitor_hold = (upd_state == trig_route_pkg::UPD_HOLD);

    ////////////////////////////////////////////////////////////////////////////////
    // break request

    logic cause_hit;
    logic explicit_brk;
    logic next_break_req;
    logic next_reset_release;

    assign explicit_brk = wr_access && idx == 3'h5 && pwdata[0];

    always_comb begin
        cause_hit = (break_en[trig_route_pkg::BRK_SOFT_BP] && soft_bp_hit)
            || (break_en[trig_route_pkg::BRK_ROM] && mem_write && rom_mapped)
            || (break_en[trig_route_pkg::BRK_COAX] && coax_rise)
            || (break_en[trig_route_pkg::BRK_BUS] && bus_sync)
            || (break_en[trig_route_pkg::BRK_LINE_A] && trig_lines.line_a)
            || (break_en[trig_route_pkg::BRK_LINE_B] && trig_lines.line_b);
        next_break_req = break_req;
        // a prefetched instruction may still finish before ack
        if (monitor_ack) begin
            next_break_req = 1'b0;
        end
        // enabled cause hit or explicit request; set wins over ack
        if (cause_hit || explicit_brk) begin
            next_break_req = 1'b1;
        end
        next_reset_release = explicit_brk && proc_in_reset;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            break_req <= 1'b0;
            reset_release <= 1'b0;
        end else if (ce) begin
            break_req <= next_break_req;
            reset_release <= next_reset_release;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup cycle

    logic [31:0] next_prdata;

    always_comb begin
        next_prdata = prdata;
        if (setup_rd) begin
            next_prdata = 32'h0;
            if (idx == 3'h0) begin
                next_prdata[3:0] = ana_sel;
            end else if (idx == 3'h1) begin
                next_prdata[3:0] = coax_ctl;
            end else if (idx == 3'h2) begin
                next_prdata[3:0] = bus_ctl;
            end else if (idx == 3'h3) begin
                next_prdata[5:0] = break_en;
            end else if (idx == 3'h4) begin
                next_prdata[5:0] = unknown;
            end else if (idx == 3'h6) begin
                next_prdata[7:0] = {monitor_hold, reset_release, break_req, bus_sync, coax_sync,
                    coax_trig_out, trig_lines.line_b, trig_lines.line_a};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (ce) begin
            prdata <= next_prdata;
        end
    end

endmodule : cross_trigger_router

/* File: verification/cross_trigger_router_monitor.sv */
// Purpose: port checker for the cross-trigger router
// Assumes: ce held high around trigger traffic
// Notes: select shadows follow apb writes
`timescale 1ns/1ps
module cross_trigger_router_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic emu_trig_found,
    input wire logic state_trig_found,
    input wire logic coax_trig_in,
    input wire logic coax_trig_out,
    input wire logic bus_trig_out,
    input trig_route_pkg::trig_lines_t trig_lines,
    input wire logic target_hw_reset,
    input wire logic proc_in_reset,
    input wire logic reset_release,
    input wire logic monitor_hold
);
    logic [3:0] ana, coax, bus, ce_h, next_ana, next_coax, next_bus, next_ce_h;
    logic cfg, next_cfg, wr;
    ////////////////////////////////////////////////////////////
    assign wr = ce && psel && penable && pwrite;
    always_comb begin
        next_ana = ana;
        next_coax = coax;
        next_bus = bus;
        next_cfg = cfg;
        next_ce_h = {ce_h[2:0], ce};
        if (wr && paddr == trig_route_pkg::OFS_ANALYZER_SEL) next_ana = pwdata[3:0];
        if (wr && paddr == trig_route_pkg::OFS_COAX_CTL) next_coax = pwdata[3:0];
        if (wr && paddr == trig_route_pkg::OFS_BUS_CTL) next_bus = pwdata[3:0];
        if (wr && paddr <= trig_route_pkg::OFS_BUS_CTL) next_cfg = 1'b1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {ana, coax, bus, ce_h, cfg} <= '0;
        end else begin
            {ana, coax, bus, ce_h, cfg} <= {next_ana, next_coax, next_bus, next_ce_h, next_cfg};
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_no_route; !cfg |-> trig_lines == 2'h0; endproperty
    a_no_route: assert property (p_no_route) else $error("line driven with no routing");
    property p_emu;
        $past(ce && emu_trig_found) |-> ($past(ana[1:0]) != trig_route_pkg::SEL_A || trig_lines.line_a)
            && ($past(ana[1:0]) != trig_route_pkg::SEL_B || trig_lines.line_b);
    endproperty
    a_emu: assert property (p_emu) else $error("emulation trigger not routed");
    property p_state;
        $past(ce && state_trig_found) |-> ($past(ana[3:2]) != trig_route_pkg::SEL_A || trig_lines.line_a)
            && ($past(ana[3:2]) != trig_route_pkg::SEL_B || trig_lines.line_b);
    endproperty
    a_state: assert property (p_state) else $error("state trigger not routed");
    property p_coax_out;
        $past(ce) |-> coax_trig_out == ($past(coax[3:2]) != 2'h0
            && (2'($past(trig_lines)) & $past(coax[3:2])) == $past(coax[3:2]));
    endproperty
    a_coax_out: assert property (p_coax_out) else $error("coax output wrong");
    property p_bus_out;
        $past(ce) |-> bus_trig_out == ($past(bus[3:2]) != 2'h0
            && (2'($past(trig_lines)) & $past(bus[3:2])) == $past(bus[3:2]));
    endproperty
    a_bus_out: assert property (p_bus_out) else $error("bus output wrong");
    property p_coax_drv; &ce_h && $past(coax_trig_in, 3) && $past(coax[0]) |-> trig_lines.line_a; endproperty
    a_coax_drv: assert property (p_coax_drv) else $error("coax input not driving line a");
    property p_hold;
        disable iff (!rst_n || target_hw_reset)
        $rose(monitor_hold) |-> monitor_hold[*4] ##1 !monitor_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("hold length wrong");
    property p_read;
        ce && psel && penable && !pwrite && !monitor_hold && paddr == trig_route_pkg::OFS_BREAK_EN
            |=> !monitor_hold;
    endproperty
    a_read: assert property (p_read) else $error("enable read entered hold");
    property p_rel; reset_release |-> $past(proc_in_reset) ##1 !reset_release; endproperty
    a_rel: assert property (p_rel) else $error("reset release pulse wrong");
    c_loop: cover property (trig_lines.line_a && coax_trig_out && !emu_trig_found);
    c_hold: cover property ($rose(monitor_hold));
    c_rel: cover property (reset_release);
endmodule : cross_trigger_router_monitor

bind cross_trigger_router cross_trigger_router_monitor cross_trigger_router_monitor_i (.clk, .rst_n, .ce,
    .psel, .penable, .pwrite, .paddr, .pwdata, .emu_trig_found, .state_trig_found, .coax_trig_in,
    .coax_trig_out, .bus_trig_out, .trig_lines, .target_hw_reset, .proc_in_reset, .reset_release,
    .monitor_hold);

/* File: verification/ext_trigger_model.sv */
// Purpose: far side: instruments on coax and bus, processor ack
// Assumes: levels set by the bench after a clock edge
// Notes: loop_en wires coax output back onto the connector
`timescale 1ns/1ps
module ext_trigger_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic coax_lvl,
    input wire logic bus_lvl,
    input wire logic loop_en,
    input wire logic ack_slow,
    input wire logic coax_trig_out,
    input wire logic break_req,
    output logic coax_trig_in,
    output logic bus_trig_in,
    output logic monitor_ack
);
    logic [2:0] cnt;
    assign coax_trig_in = coax_lvl | (loop_en & coax_trig_out);
    assign bus_trig_in = bus_lvl;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
            monitor_ack <= 1'b0;
        end else begin
            monitor_ack <= 1'b0;
            cnt <= cnt + 3'h1;
            if (!break_req || monitor_ack) begin
                cnt <= 3'h0;
            end else if (cnt == (ack_slow ? 3'h6 : 3'h1)) begin
                monitor_ack <= 1'b1;
            end
        end
    end
endmodule : ext_trigger_model

/* File: verification/cross_trigger_router_tb_top.sv */
// Purpose: directed apb and trigger sequences for the router
// Assumes: zero-wait apb, latencies as handed over
// Notes: ce held high throughout
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module cross_trigger_router_tb_top;
    logic clk, rst_n, ce, psel, penable, pwrite, err, emu_trig_found, state_trig_found, coax_trig_in;
    logic coax_trig_out, bus_trig_in, bus_trig_out, soft_bp_hit, mem_write, rom_mapped, target_hw_reset;
    logic proc_in_reset, monitor_ack, break_req, reset_release, monitor_hold, pready, pslverr;
    logic coax_lvl, bus_lvl, loop_en, ack_slow, brk_seen, rel_seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    trig_route_pkg::trig_lines_t trig_lines;
    int fails = 0;
    int num_checks = 0;
    cross_trigger_router cross_trigger_router_i (.clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .emu_trig_found, .state_trig_found, .coax_trig_in, .coax_trig_out,
        .bus_trig_in, .bus_trig_out, .trig_lines, .soft_bp_hit, .mem_write, .rom_mapped, .target_hw_reset,
        .proc_in_reset, .monitor_ack, .break_req, .reset_release, .monitor_hold);
    ext_trigger_model ext_trigger_model_i (.clk, .rst_n, .coax_lvl, .bus_lvl, .loop_en, .ack_slow,
        .coax_trig_out, .break_req, .coax_trig_in, .bus_trig_in, .monitor_ack);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (break_req === 1'b1) brk_seen <= 1'b1;
        if (reset_release === 1'b1) rel_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            wrap_up();
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(a, 1'b1, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(a, 1'b0, 32'h0, r);
        `CHK(r, e)
    endtask : rd
    function automatic logic [1:0] lines_of(input int c);
        return c == 1 ? 2'h1 : (c == 2 ? 2'h2 : 2'h0);
    endfunction : lines_of
    ////////////////////////////////////////////////////////////
    initial begin
        {rst_n, psel, penable, pwrite, emu_trig_found, state_trig_found, soft_bp_hit, mem_write} = '0;
        {rom_mapped, target_hw_reset, proc_in_reset, coax_lvl, bus_lvl, loop_en, ack_slow} = '0;
        {brk_seen, rel_seen, err} = '0;
        ce = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        cyc(8);
        rst_n <= 1'b1;
        cyc(1);
        rd(trig_route_pkg::OFS_ANALYZER_SEL, 32'h0);
        rd(trig_route_pkg::OFS_COAX_CTL, 32'h0);
        rd(trig_route_pkg::OFS_BREAK_EN, 32'h1);
        rd(8'h40, 32'h0);
        `CHK(err, 1'b1)
        for (int i = 0; i < 4; i++) begin
            wr(trig_route_pkg::OFS_ANALYZER_SEL, 32'(i + (3 - i) * 4));
            rd(trig_route_pkg::OFS_ANALYZER_SEL, 32'(i + (3 - i) * 4));
            emu_trig_found <= 1'b1;
            cyc(3);
            `CHK(trig_lines, lines_of(i))
            emu_trig_found <= 1'b0;
            state_trig_found <= 1'b1;
            cyc(3);
            `CHK(trig_lines, lines_of(3 - i))
            state_trig_found <= 1'b0;
            cyc(3);
        end
        wr(trig_route_pkg::OFS_ANALYZER_SEL, 32'h0);
        for (int d = 1; d < 4; d++) begin
            wr(trig_route_pkg::OFS_COAX_CTL, 32'(d + 12));
            wr(trig_route_pkg::OFS_BUS_CTL, 32'(d * 4));
            coax_lvl <= 1'b1;
            cyc(6);
            `CHK(trig_lines, 2'(d))
            `CHK(coax_trig_out, 1'(d == 3))
            `CHK(bus_trig_out, 1'b1)
            coax_lvl <= 1'b0;
            cyc(6);
            `CHK(trig_lines, 2'h0)
        end
        wr(trig_route_pkg::OFS_BUS_CTL, 32'h2);
        bus_lvl <= 1'b1;
        cyc(6);
        `CHK(trig_lines, 2'h2)
        bus_lvl <= 1'b0;
        wr(trig_route_pkg::OFS_BUS_CTL, 32'h0);
        wr(trig_route_pkg::OFS_COAX_CTL, 32'h5);
        wr(trig_route_pkg::OFS_ANALYZER_SEL, 32'h1);
        loop_en <= 1'b1;
        emu_trig_found <= 1'b1;
        // source held past the round trip through the synchroniser
        cyc(4);
        emu_trig_found <= 1'b0;
        cyc(10);
        `CHK(trig_lines, 2'h1)
        rd(trig_route_pkg::OFS_STATUS, 32'hd);
        wr(trig_route_pkg::OFS_ANALYZER_SEL, 32'h0);
        wr(trig_route_pkg::OFS_COAX_CTL, 32'h4);
        cyc(6);
        wr(trig_route_pkg::OFS_COAX_CTL, 32'h5);
        cyc(6);
        `CHK(trig_lines, 2'h0)
        loop_en <= 1'b0;
        wr(trig_route_pkg::OFS_COAX_CTL, 32'h0);
        wr(trig_route_pkg::OFS_BREAK_EN, 32'h2);
        `CHK(monitor_hold, 1'b1)
        cyc(8);
        `CHK(monitor_hold, 1'b0)
        rd(trig_route_pkg::OFS_BREAK_EN, 32'h2);
        brk_seen <= 1'b0;
        soft_bp_hit <= 1'b1;
        cyc(1);
        soft_bp_hit <= 1'b0;
        cyc(6);
        `CHK(brk_seen, 1'b0)
        ack_slow <= 1'b1;
        mem_write <= 1'b1;
        rom_mapped <= 1'b1;
        cyc(1);
        {mem_write, rom_mapped} <= 2'h0;
        cyc(12);
        `CHK(brk_seen, 1'b1)
        `CHK(break_req, 1'b0)
        wr(trig_route_pkg::OFS_BREAK_EN, 32'h8);
        cyc(6);
        brk_seen <= 1'b0;
        bus_lvl <= 1'b1;
        cyc(4);
        bus_lvl <= 1'b0;
        cyc(14);
        `CHK(brk_seen, 1'b1)
        `CHK(break_req, 1'b0)
        proc_in_reset <= 1'b1;
        wr(trig_route_pkg::OFS_BREAK_CMD, 32'h1);
        cyc(6);
        `CHK(rel_seen, 1'b1)
        proc_in_reset <= 1'b0;
        wr(trig_route_pkg::OFS_BREAK_EN, 32'h3f);
        target_hw_reset <= 1'b1;
        cyc(1);
        target_hw_reset <= 1'b0;
        cyc(8);
        rd(trig_route_pkg::OFS_BREAK_UNKNOWN, 32'h37);
        rd(trig_route_pkg::OFS_BREAK_EN, 32'h8);
        wrap_up();
    end
endmodule : cross_trigger_router_tb_top
